// File: design/pci_port_map.vh
`ifndef PCI_PORT_MAP_VH
`define PCI_PORT_MAP_VH
// ------------------------------------------------------------
// Bus encodings and limits
// ------------------------------------------------------------
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define BURST_MAX_BYTES 7'h40
`define BURST_MAX_WORDS 5'h10
`define XFER_LEN_W 16
`define BUF_DEPTH_LOG2 4
`endif

// File: design/burst_buffer.v
// ------------------------------------------------------------
// Word store with separate write and read ports for one initiator burst
// ------------------------------------------------------------
module burst_buffer (
   input wire clk,
   input wire we,
   input wire [3:0] waddr,
   input wire [31:0] wdata,
   input wire [3:0] raddr,
   output reg [31:0] rdata_ff
);
   reg [31:0] mem [0:15];

   // Registered read, written word visible next cycle
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_ff <= mem[raddr];
   end
endmodule // burst_buffer

// File: design/pci_burst_port.v
`include "pci_port_map.vh"
// ------------------------------------------------------------
// Dual-role bus port: target side and burst-limited initiator
// ------------------------------------------------------------
// Overview of operation
// - Port answers external masters as target and starts its own transfers.
// - Initiator bursts never carry more than 64 bytes.
// - Long initiator transfers split into 64-byte bursts until done, the last one carrying any shorter remainder.
// - Initiator data comes from or goes to the internal DMA engine.
// - Target bursts of any length are accepted without a byte cap.
// - Target retries instead of adding wait states when it cannot serve in time.
// - Target retries while internal memory reports it cannot serve.
module pci_burst_port (
   input wire clk,
   input wire rst_n,
   // Internal DMA engine request
   input wire dma_req,
   input wire dma_write,
   input wire [31:0] dma_addr,
   input wire [`XFER_LEN_W-1:0] dma_words,
   output reg dma_busy_ff,
   output reg dma_done_ff,
   input wire dma_wvalid,
   input wire [31:0] dma_wdata,
   output reg dma_wready_ff,
   output reg dma_rvalid_ff,
   output reg [31:0] dma_rdata_ff,
   // Initiator bus side
   output reg ini_frame_ff,
   output reg [3:0] ini_cmd_ff,
   output reg [31:0] ini_addr_ff,
   output reg ini_wvalid_ff,
   output reg [31:0] ini_wdata_ff,
   output reg ini_last_ff,
   input wire ini_ack,
   input wire [31:0] ini_rdata,
   // Target bus side
   input wire tgt_frame,
   input wire tgt_write,
   input wire [31:0] tgt_addr,
   input wire [31:0] tgt_wdata,
   output reg tgt_ready_ff,
   output reg tgt_retry_ff,
   output reg [31:0] tgt_rdata_ff,
   // Internal memory side
   input wire mem_ready,
   input wire [31:0] mem_rdata,
   output reg mem_req_ff,
   output reg mem_we_ff,
   output reg [31:0] mem_addr_ff,
   output reg [31:0] mem_wdata_ff
);
   localparam S_IDLE = 3'h0;
   localparam S_FILL = 3'h1;
   localparam S_BURST = 3'h2;
   localparam S_DRAIN = 3'h3;
   localparam S_NEXT = 3'h4;

   reg [2:0] state_ff;
   reg is_write_ff;
   reg [31:0] addr_ff;
   reg [`XFER_LEN_W-1:0] left_ff;
   reg [4:0] chunk_ff;
   reg [4:0] idx_ff;
   reg tgt_frame_s1_ff, tgt_frame_s2_ff;
   reg tgt_mem_ready_s1_ff, tgt_mem_ready_s2_ff;
   wire [31:0] buf_rdata;
   wire buf_we;
   wire [3:0] buf_waddr;
   wire [31:0] buf_wdata;
   wire [3:0] nxt_raddr;
   reg tgt_write_s1_ff, tgt_write_s2_ff;
   reg [31:0] tgt_addr_s1_ff, tgt_addr_s2_ff;
   reg [31:0] tgt_wdata_s1_ff, tgt_wdata_s2_ff;
   reg [31:0] mem_rdata_s1_ff, mem_rdata_s2_ff;

   // Burst length: remaining words capped at 16 words (64 bytes)
   function [4:0] chunk_of;
      input [`XFER_LEN_W-1:0] left;
      begin
         if (left > {{(`XFER_LEN_W-5){1'b0}}, `BURST_MAX_WORDS}) begin
            chunk_of = `BURST_MAX_WORDS;
         end else begin
            chunk_of = left[4:0];
         end
      end
   endfunction

   // Buffer written from DMA on fill, from bus on read bursts
   assign buf_we = (state_ff == S_FILL && dma_wvalid && dma_wready_ff) ||
                   (state_ff == S_BURST && !is_write_ff && ini_ack);
   assign buf_waddr = idx_ff[3:0];
   assign buf_wdata = (state_ff == S_FILL) ? dma_wdata : ini_rdata;

   burst_buffer u_buf (
      .clk(clk),
      .we(buf_we),
      .waddr(buf_waddr),
      .wdata(buf_wdata),
      .raddr(nxt_raddr),
      .rdata_ff(buf_rdata)
   );

   // Read pointer runs one word ahead of the bus beat, so the
   // registered store already holds the next word when a beat is taken
   assign nxt_raddr = idx_ff[3:0] +
                      ((state_ff == S_BURST && ini_ack) ? 4'h2 : 4'h1);

   // ------------------------------------------------------------
   // Initiator sequencer
   // ------------------------------------------------------------
   // Fill (writes only), drain, burst, repeat; address advances by bytes moved (four per word)
   always @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
         is_write_ff <= 1'b0;
         addr_ff <= 32'h0;
         left_ff <= {`XFER_LEN_W{1'b0}};
         chunk_ff <= 5'h0;
         idx_ff <= 5'h0;
         dma_busy_ff <= 1'b0;
         dma_done_ff <= 1'b0;
         dma_wready_ff <= 1'b0;
         dma_rvalid_ff <= 1'b0;
         dma_rdata_ff <= 32'h0;
         ini_frame_ff <= 1'b0;
         ini_cmd_ff <= 4'h0;
         ini_addr_ff <= 32'h0;
         ini_wvalid_ff <= 1'b0;
         ini_wdata_ff <= 32'h0;
         ini_last_ff <= 1'b0;
      end else begin
         dma_done_ff <= 1'b0;
         dma_rvalid_ff <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               if (dma_req && dma_words != {`XFER_LEN_W{1'b0}}) begin
                  is_write_ff <= dma_write;
                  addr_ff <= dma_addr;
                  left_ff <= dma_words;
                  dma_busy_ff <= 1'b1;
                  state_ff <= S_NEXT;
               end
            end
            S_NEXT: begin
               chunk_ff <= chunk_of(left_ff);
               idx_ff <= 5'h0;
               if (is_write_ff) begin
                  dma_wready_ff <= 1'b1;
                  state_ff <= S_FILL;
               end else begin
                  // Reads pass drain too, so bursts stay two cycles apart
                  state_ff <= S_DRAIN;
               end
            end
            S_FILL: begin
               if (dma_wvalid) begin
                  idx_ff <= idx_ff + 5'h1;
                  // Word 0 bypasses the store, no extra read cycle needed
                  if (idx_ff == 5'h0) begin
                     ini_wdata_ff <= dma_wdata;
                  end
                  if (idx_ff + 5'h1 == chunk_ff) begin
                     dma_wready_ff <= 1'b0;
                     idx_ff <= 5'h0;
                     state_ff <= S_DRAIN;
                  end
               end
            end
            S_DRAIN: begin
               // Open the burst while word 1 is fetched from the store
               ini_frame_ff <= 1'b1;
               ini_cmd_ff <= is_write_ff ? `CMD_MEM_WRITE : `CMD_MEM_READ;
               ini_addr_ff <= addr_ff;
               ini_wvalid_ff <= is_write_ff;
               ini_last_ff <= (chunk_ff == 5'h1);
               state_ff <= S_BURST;
            end
            S_BURST: begin
               if (!is_write_ff) begin
                  dma_rvalid_ff <= ini_ack;
                  dma_rdata_ff <= ini_rdata;
               end else if (ini_ack) begin
                  ini_wdata_ff <= buf_rdata;
               end
               if (ini_ack) begin
                  idx_ff <= idx_ff + 5'h1;
                  ini_last_ff <= (idx_ff + 5'h2 == chunk_ff);
                  if (idx_ff + 5'h1 == chunk_ff) begin
                     // End burst after chunk_ff beats, resume after last byte
                     ini_frame_ff <= 1'b0;
                     ini_wvalid_ff <= 1'b0;
                     ini_last_ff <= 1'b0;
                     addr_ff <= addr_ff + {25'h0, chunk_ff, 2'h0};
                     left_ff <= left_ff - {{(`XFER_LEN_W-5){1'b0}}, chunk_ff};
                     if (left_ff == {{(`XFER_LEN_W-5){1'b0}}, chunk_ff}) begin
                        dma_busy_ff <= 1'b0;
                        dma_done_ff <= 1'b1;
                        state_ff <= S_IDLE;
                     end else begin
                        state_ff <= S_NEXT;
                     end
                  end
               end
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Target side
   // ------------------------------------------------------------
   // Pin and memory synchronisers; data words ride the same two stages
   // as their qualifier so they stay aligned with it
   always @(posedge clk) begin
      if (!rst_n) begin
         tgt_frame_s1_ff <= 1'b0;
         tgt_frame_s2_ff <= 1'b0;
         tgt_mem_ready_s1_ff <= 1'b0;
         tgt_mem_ready_s2_ff <= 1'b0;
         tgt_write_s1_ff <= 1'b0;
         tgt_write_s2_ff <= 1'b0;
         tgt_addr_s1_ff <= 32'h0;
         tgt_addr_s2_ff <= 32'h0;
         tgt_wdata_s1_ff <= 32'h0;
         tgt_wdata_s2_ff <= 32'h0;
         mem_rdata_s1_ff <= 32'h0;
         mem_rdata_s2_ff <= 32'h0;
      end else begin
         tgt_frame_s1_ff <= tgt_frame;
         tgt_frame_s2_ff <= tgt_frame_s1_ff;
         tgt_mem_ready_s1_ff <= mem_ready;
         tgt_mem_ready_s2_ff <= tgt_mem_ready_s1_ff;
         tgt_write_s1_ff <= tgt_write;
         tgt_write_s2_ff <= tgt_write_s1_ff;
         tgt_addr_s1_ff <= tgt_addr;
         tgt_addr_s2_ff <= tgt_addr_s1_ff;
         tgt_wdata_s1_ff <= tgt_wdata;
         tgt_wdata_s2_ff <= tgt_wdata_s1_ff;
         mem_rdata_s1_ff <= mem_rdata;
         mem_rdata_s2_ff <= mem_rdata_s1_ff;
      end
   end

   // No beat counter: a burst runs as long as the master holds frame
   always @(posedge clk) begin
      if (!rst_n) begin
         tgt_ready_ff <= 1'b0;
         tgt_retry_ff <= 1'b0;
         tgt_rdata_ff <= 32'h0;
         mem_req_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_addr_ff <= 32'h0;
         mem_wdata_ff <= 32'h0;
      end else begin
         tgt_ready_ff <= 1'b0;
         tgt_retry_ff <= 1'b0;
         mem_req_ff <= 1'b0;
         if (tgt_frame_s2_ff) begin
            if (tgt_mem_ready_s2_ff) begin
               tgt_ready_ff <= 1'b1;
               mem_req_ff <= 1'b1;
               mem_we_ff <= tgt_write_s2_ff;
               mem_addr_ff <= tgt_addr_s2_ff;
               mem_wdata_ff <= tgt_wdata_s2_ff;
               tgt_rdata_ff <= mem_rdata_s2_ff;
            end else begin
               // Memory stalled: retry instead of holding the bus
               tgt_retry_ff <= 1'b1;
            end
         end
      end
   end
endmodule // pci_burst_port

// File: dv/pci_burst_port_sva.sv
`include "pci_port_map.vh"
// ------------------------------------------------------------
// Port timing checker
// ------------------------------------------------------------
module pci_burst_port_chk (
   input wire clk,
   input wire rst_n,
   input wire dma_req,
   input wire [`XFER_LEN_W-1:0] dma_words,
   input wire dma_busy_ff,
   input wire dma_done_ff,
   input wire ini_frame_ff,
   input wire [3:0] ini_cmd_ff,
   input wire [31:0] ini_addr_ff,
   input wire ini_last_ff,
   input wire ini_ack,
   input wire tgt_frame,
   input wire tgt_ready_ff,
   input wire tgt_retry_ff,
   input wire mem_req_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [4:0] beat_cnt_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Beats taken in the current burst, cleared between bursts
   always @(posedge clk) begin
      if (!rst_n || !ini_frame_ff) beat_cnt_ff <= 5'h00;
      else if (ini_ack) beat_cnt_ff <= beat_cnt_ff + 5'h01;
   end
   chk_burst_cap: assert property (
      ini_frame_ff && ini_ack |-> beat_cnt_ff < 5'h10)
      else $error("burst longer than sixteen words");
   chk_last_ends: assert property (
      ini_frame_ff && ini_ack && ini_last_ff |=> !ini_frame_ff)
      else $error("burst runs past its last beat");
   chk_burst_gap: assert property (
      $fell(ini_frame_ff) |-> !ini_frame_ff ##1 !ini_frame_ff)
      else $error("bursts closer than two cycles");
   chk_addr_held: assert property (
      ini_frame_ff && $past(ini_frame_ff) |-> $stable(ini_addr_ff))
      else $error("burst address moved mid burst");
   chk_cmd_code: assert property (
      ini_frame_ff |-> ini_cmd_ff == 4'h6 || ini_cmd_ff == 4'h7)
      else $error("burst command not read or write");
   chk_busy_start: assert property (
      dma_req && !dma_busy_ff && !dma_done_ff && dma_words != 0
      |=> dma_busy_ff) else $error("request not taken");
   chk_done_pulse: assert property (
      dma_done_ff |=> !dma_done_ff) else $error("done longer than a cycle");
   chk_tgt_answer: assert property (
      $rose(tgt_frame) |-> ##3 (tgt_ready_ff || tgt_retry_ff))
      else $error("target access unanswered");
   chk_ready_retry: assert property (
      !(tgt_ready_ff && tgt_retry_ff)) else $error("ready and retry together");
   chk_ready_mem: assert property (
      tgt_ready_ff |-> mem_req_ff) else $error("served beat without memory");
endmodule // pci_burst_port_chk
bind pci_burst_port pci_burst_port_chk chk_i (.clk(clk), .rst_n(rst_n),
   .dma_req(dma_req), .dma_words(dma_words), .dma_busy_ff(dma_busy_ff),
   .dma_done_ff(dma_done_ff), .ini_frame_ff(ini_frame_ff),
   .ini_cmd_ff(ini_cmd_ff), .ini_addr_ff(ini_addr_ff),
   .ini_last_ff(ini_last_ff), .ini_ack(ini_ack), .tgt_frame(tgt_frame),
   .tgt_ready_ff(tgt_ready_ff), .tgt_retry_ff(tgt_retry_ff),
   .mem_req_ff(mem_req_ff));

// File: dv/pci_far_model.sv
// ------------------------------------------------------------
// Bus target answering initiator bursts, with random stalls
// ------------------------------------------------------------
module pci_far_model (
   input wire clk,
   input wire rst_n,
   input wire ini_frame_ff,
   input wire ini_last_ff,
   input wire [31:0] ini_addr_ff,
   output logic ini_ack,
   output logic [31:0] ini_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 32'h2389;
   logic [4:0] beat_ff;
   logic nxt_ack;
   // Read data tracks the beat address; noise while not acking
   always @(posedge clk) begin
      nxt_ack = ini_frame_ff && !(ini_ack && ini_last_ff)
                && ($random(seed) & 3) != 0;
      if (!rst_n || !ini_frame_ff) beat_ff <= 5'h00;
      else if (ini_ack) beat_ff <= beat_ff + 5'h01;
      ini_ack <= rst_n && nxt_ack;
      ini_rdata <= nxt_ack ? ~(ini_addr_ff + {beat_ff + ini_ack, 2'h0})
                           : $random(seed);
   end
endmodule // pci_far_model

// File: dv/tb_top.sv
// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, dma_req = 0, dma_write = 0, dma_wvalid = 0;
   logic tgt_frame = 0, tgt_write = 0, mem_ready = 1, fr_prev = 0;
   logic [31:0] dma_addr = 0, dma_wdata = 0, tgt_addr = 0, tgt_wdata = 0;
   logic [31:0] mem_rdata = 0, base = 0;
   logic [15:0] dma_words = 0;
   logic [96:0] tq1 = 0, tq2 = 0, tq3 = 0;
   wire dma_busy_ff, dma_done_ff, dma_wready_ff, dma_rvalid_ff, ini_ack;
   wire ini_frame_ff, ini_wvalid_ff, ini_last_ff, tgt_ready_ff, tgt_retry_ff;
   wire mem_req_ff, mem_we_ff;
   wire [31:0] dma_rdata_ff, ini_addr_ff, ini_wdata_ff, ini_rdata;
   wire [31:0] tgt_rdata_ff, mem_addr_ff, mem_wdata_ff;
   wire [3:0] ini_cmd_ff;
   integer seed = 32'h2389, err_total = 0, checks = 0, cyc = 0, n, i;
   integer beats = 0, bursts = 0, rbeats = 0, widx = 0, rdy = 0, rty = 0;
   integer corner [0:4] = '{1, 16, 17, 32, 33};
   pci_burst_port uut (.clk(clk), .rst_n(rst_n), .dma_req(dma_req),
      .dma_write(dma_write), .dma_addr(dma_addr), .dma_words(dma_words),
      .dma_busy_ff(dma_busy_ff), .dma_done_ff(dma_done_ff),
      .dma_wvalid(dma_wvalid), .dma_wdata(dma_wdata),
      .dma_wready_ff(dma_wready_ff), .dma_rvalid_ff(dma_rvalid_ff),
      .dma_rdata_ff(dma_rdata_ff), .ini_frame_ff(ini_frame_ff),
      .ini_cmd_ff(ini_cmd_ff), .ini_addr_ff(ini_addr_ff),
      .ini_wvalid_ff(ini_wvalid_ff), .ini_wdata_ff(ini_wdata_ff),
      .ini_last_ff(ini_last_ff), .ini_ack(ini_ack), .ini_rdata(ini_rdata),
      .tgt_frame(tgt_frame), .tgt_write(tgt_write), .tgt_addr(tgt_addr),
      .tgt_wdata(tgt_wdata), .tgt_ready_ff(tgt_ready_ff),
      .tgt_retry_ff(tgt_retry_ff), .tgt_rdata_ff(tgt_rdata_ff),
      .mem_ready(mem_ready), .mem_rdata(mem_rdata), .mem_req_ff(mem_req_ff),
      .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
      .mem_wdata_ff(mem_wdata_ff));
   pci_far_model far_i (.clk(clk), .rst_n(rst_n), .ini_frame_ff(ini_frame_ff),
      .ini_last_ff(ini_last_ff), .ini_addr_ff(ini_addr_ff), .ini_ack(ini_ack),
      .ini_rdata(ini_rdata));
   always #10 clk = ~clk;
   // Write word k carries its own index, so skips show
   function [31:0] pat(input integer k);
      pat = {16'hA5C3, k[15:0]};
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task summarize;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Monitor of bursts, beats and target answers; timeout guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      fr_prev <= ini_frame_ff;
      mem_rdata <= $random(seed);
      tgt_addr <= $random(seed);
      tgt_wdata <= $random(seed);
      tgt_write <= $random(seed);
      // Target words reach memory three edges after the bench drove them
      tq1 <= {tgt_write, tgt_addr, tgt_wdata, mem_rdata};
      tq2 <= tq1;
      tq3 <= tq2;
      if (mem_req_ff) begin
         chk(mem_addr_ff, tq3[95:64]);
         chk(mem_wdata_ff, tq3[63:32]);
         chk(tgt_rdata_ff, tq3[31:0]);
         chk(mem_we_ff, tq3[96]);
      end
      if (ini_frame_ff && !fr_prev) begin
         chk(ini_addr_ff, base + 64 * bursts);
         chk(ini_cmd_ff, dma_write ? 7 : 6);
         bursts++;
      end
      if (ini_frame_ff && ini_ack) begin
         if (dma_write) chk(ini_wdata_ff, pat(beats));
         chk(ini_wvalid_ff, dma_write);
         beats++;
      end
      if (dma_rvalid_ff) begin
         chk(dma_rdata_ff, ~(base + 4 * rbeats));
         rbeats++;
      end
      if (dma_wvalid && dma_wready_ff) begin
         widx++;
         dma_wdata <= pat(widx);
      end
      rdy += tgt_ready_ff;
      rty += tgt_retry_ff;
      if (cyc == 60000) begin
         err_total++;
         summarize;
      end
   end
   task dma_run(input logic wr, input integer words);
      @(posedge clk);
      base = $random(seed) & 32'hFFFFFFFC;
      {beats, bursts, rbeats, widx, n} = 0;
      dma_addr <= base;
      dma_words <= words[15:0];
      dma_write <= wr;
      dma_wdata <= pat(0);
      dma_wvalid <= wr;
      dma_req <= 1;
      do begin @(posedge clk); #1; n++; end
      while (dma_busy_ff !== 1'b1 && n < 20);
      @(posedge clk);
      dma_req <= 0;
      while (dma_done_ff !== 1'b1 && n < 5000) begin @(posedge clk); #1; n++; end
      @(posedge clk);
      dma_wvalid <= 0;
      @(posedge clk);
      #1;
      chk(beats, words);
      chk(bursts, (words + 15) / 16);
      chk(rbeats, wr ? 0 : words);
   endtask
   task tgt_run(input logic ready_in, input integer len);
      @(posedge clk);
      mem_ready <= ready_in;
      repeat (4) @(posedge clk);
      #1 {rdy, rty} = 0;
      @(posedge clk);
      tgt_frame <= 1;
      repeat (len) @(posedge clk);
      tgt_frame <= 0;
      repeat (6) @(posedge clk);
      #1;
      if (ready_in) chk(rdy >= len - 2 && rty == 0, 1);
      else chk(rdy == 0 && rty >= len - 4, 1);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1;
      for (i = 0; i < 10; i++) begin
         dma_run(i[0], i < 5 ? corner[i] : 1 + ($random(seed) & 47));
         $display("dma test %0d done", i);
      end
      tgt_run(1, 40);
      $display("target long burst done");
      tgt_run(0, 20);
      $display("target retry done");
      summarize;
   end
endmodule // tb_top
